// *** core/ddrdio_pkg.sv ***
// shared constants and types of the ddr dual-line read engine
package ddrdio_pkg;

  // opcodes, sent single-line at single data rate
  localparam logic [7:0] OPC_DUAL_DDR  = 8'hbd; // address length follows the setting
  localparam logic [7:0] OPC_DUAL_DDR4 = 8'hbe; // always four address bytes

  // phase lengths in serial clock cycles (four bits move per cycle after the opcode)
  localparam logic [7:0] OPC_BITS  = 8'h08; // one bit per cycle
  localparam logic [7:0] ADDR3_CYC = 8'h06; // three address bytes
  localparam logic [7:0] ADDR4_CYC = 8'h08; // four address bytes
  localparam logic [7:0] MODE_CYC  = 8'h02; // one mode byte
  localparam logic [7:0] PRE_CYC   = 8'h04; // preamble ahead of first data
  localparam logic [7:0] SHORT_CYC = 8'h08; // longest frame that counts as short
  localparam logic [7:0] FRAME_SAT = 8'hff; // frame length counter saturates here
  localparam logic [7:0] CYC_ONE   = 8'h01;

  // host-side serial clock ceiling for this command, not checked by the device
  localparam int SCK_MAX_MHZ = 80;

  // dummy cycle count for each latency code, code 0 in the low slot
  typedef logic [3:0][4:0] ddrdio_dmy_t;
  localparam ddrdio_dmy_t DUMMY_TAB_DEF = {5'h08, 5'h07, 5'h06, 5'h05};

  // frame sequencer, gray along first -> opcode -> address -> mode -> dummy -> data
  typedef enum logic [2:0] {
    S_FIRST  = 3'h0,
    S_OPC    = 3'h1,
    S_ADDR   = 3'h3,
    S_MODE   = 3'h2,
    S_DUMMY  = 3'h6,
    S_DATA   = 3'h7,
    S_IGNORE = 3'h5
  } ddrdio_st_t;

  // configuration bits, quasi-static
  typedef struct packed {
    logic       extendedAddressEnable; // 4-byte address for the first opcode
    logic       enhancedLatencyTable;  // 1: mode byte present, 0: basic table
    logic       learnPatternEnable;    // drive the learning preamble
    logic [1:0] latencyCode;           // selects the dummy count
    logic [7:0] learnPattern;          // preamble byte, msb first
  } ddrdio_cfg_t;

  // status seen on the system clock
  typedef struct packed {
    logic contMode; // opcode-less continuous mode armed
    logic busy;     // chip select active
  } ddrdio_stat_t;

endpackage

// *** core/ddrdio_read.sv ***
// ddr dual-line read engine: link logic on the serial clock, status on clk
`timescale 1ns/1ps
// Functional notes
// - opcode bdh carries 3-byte address, 4-byte when extended addressing set
// - opcode beh always carries a 4-byte address
// - data leaves on both lines, two bits on each clock edge
// - address, mode, data move two bits per edge; opcode single-line sdr
// - dummy cycles after address or mode, count picked by latency code
// - basic table: no mode cycles, opcode then address then latency
// - line values are ignored throughout the dummy cycles
// - enhanced table: complementary mode nibbles arm opcode-less next frame
// - non-complementary mode bits drop continuous mode from next frame
// - short frame of eight clocks or fewer drops continuous mode
// - any start byte; address steps by one per byte while clocks run
// - address wraps past the top to zero and streaming continues
// - pause input has no effect during this command
// - optional preamble fills the four cycles before first data
// - programmable preamble byte, same on both lines, msb first
module ddrdio_read
  import ddrdio_pkg::*;
#(
  parameter int          ADDR_W    = 24,           // array address bits
  parameter ddrdio_dmy_t DUMMY_TAB = DUMMY_TAB_DEF // dummy cycles per latency code
) (
  input  wire logic              clk,     // system clock
  input  wire logic              rst_n,   // synchronous reset, active low
  input  wire logic              sck,     // serial clock from the host
  input  wire logic              cs_n,    // chip select, active low
  input  wire logic [1:0]        ioIn,    // line one, line zero as seen on the pins
  output logic      [1:0]        ioOut,   // values driven onto the lines
  output logic      [1:0]        ioOe_n,  // low while the device drives a line
  input  wire ddrdio_cfg_t       cfg,     // configuration bits
  output logic      [ADDR_W-1:0] memAddr, // array read address, serial clock domain
  input  wire logic [7:0]        memData, // array byte at memAddr, combinational
  output ddrdio_stat_t           status   // status on the system clock
);

  logic              lnkRstN_reg;
  logic              frmRst;
  ddrdio_cfg_t       cfgS1_reg;
  ddrdio_cfg_t       cfgS_reg;
  logic [1:0]        rPair_reg;
  logic [3:0]        nib;
  ddrdio_st_t        st_reg;
  ddrdio_st_t        effSt;
  logic [7:0]        cnt_reg;
  logic [7:0]        opcSh_reg;
  logic [7:0]        opcNext;
  logic [31:0]       addrSh_reg;
  logic [31:0]       addrFull;
  logic [3:0]        modeSh_reg;
  logic [7:0]        modeByte;
  logic              modeDone;
  logic [7:0]        addrLen_reg;
  logic [7:0]        dmyLen;
  logic [ADDR_W-1:0] memAddr_reg;
  logic              contMode_reg;
  logic [7:0]        contLen_reg;
  logic [7:0]        frameCyc_reg;
  logic              effCont;
  logic              preWin;
  logic [7:0]        winPos;
  logic [2:0]        hiIdx;
  logic [2:0]        loIdx;
  logic [3:0]        curNib;
  logic              curDrv;
  logic [1:0]        posPair_reg;
  logic [1:0]        negPair_reg;
  logic              posDrv_reg;
  logic              negDrv_reg;
  logic              contS1_reg;
  logic              contS2_reg;
  logic              busyS1_reg;
  logic              busyS2_reg;

  // true when the upper mode nibble is the inverse of the lower one
  function automatic logic isComplement(input logic [7:0] b);
    isComplement = (b[7:4] == ~b[3:0]);
  endfunction

  // ---------------------------------------------------------------- system clock side

  // link reset released one clk after rst_n; the serial clock normally stands
  // still then, so releasing it asynchronously to sck is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lnkRstN_reg <= 1'b0;
    end else begin
      lnkRstN_reg <= 1'b1;
    end
  end

  // two-stage synchronisers for status levels coming from the link side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      contS1_reg <= 1'b0;
      contS2_reg <= 1'b0;
      busyS1_reg <= 1'b0;
      busyS2_reg <= 1'b0;
    end else begin
      contS1_reg <= contMode_reg;
      contS2_reg <= contS1_reg;
      busyS1_reg <= ~cs_n;
      busyS2_reg <= busyS1_reg;
    end
  end

  assign status.contMode = contS2_reg;
  assign status.busy     = busyS2_reg;

  // ---------------------------------------------------------------- serial clock side

  // select high or link reset ends the frame at once, even with sck stopped
  assign frmRst = cs_n | ~lnkRstN_reg;

  // configuration enters the serial clock domain through two stages; a change
  // therefore needs a couple of serial clocks before it takes effect
  always_ff @(posedge sck or negedge lnkRstN_reg) begin
    if (!lnkRstN_reg) begin
      cfgS1_reg <= '0;
      cfgS_reg  <= '0;
    end else begin
      cfgS1_reg <= cfg;
      cfgS_reg  <= cfgS1_reg;
    end
  end

  // rising-edge pair, joined with the falling-edge pair at the falling edge
  always_ff @(posedge sck or posedge frmRst) begin
    if (frmRst) begin
      rPair_reg <= 2'h0;
    end else begin
      rPair_reg <= ioIn;
    end
  end

  assign nib      = {rPair_reg, ioIn};
  assign opcNext  = {opcSh_reg[6:0], rPair_reg[0]}; // opcode rides line zero, rising edges
  assign addrFull = {addrSh_reg[27:0], nib};
  assign modeByte = {modeSh_reg, nib};
  assign dmyLen   = {3'h0, DUMMY_TAB[cfgS_reg.latencyCode]};
  assign modeDone = (st_reg == S_MODE) && (cnt_reg == MODE_CYC - CYC_ONE);

  // continuous mode survives into this frame only if the last one was not short
  assign effCont = contMode_reg && (frameCyc_reg > SHORT_CYC);
  assign effSt   = (st_reg != S_FIRST) ? st_reg : (effCont ? S_ADDR : S_OPC);

  // frame sequencer, advanced on the falling edge once both pairs of a cycle are in;
  // nothing here waits on a pause input, so the stream is never held
  always_ff @(negedge sck or posedge frmRst) begin
    if (frmRst) begin
      st_reg      <= S_FIRST;
      cnt_reg     <= 8'h00;
      opcSh_reg   <= 8'h00;
      addrSh_reg  <= 32'h00000000;
      modeSh_reg  <= 4'h0;
      addrLen_reg <= ADDR3_CYC;
      memAddr_reg <= '0;
    end else begin
      st_reg  <= effSt;
      cnt_reg <= cnt_reg + CYC_ONE;
      if (st_reg == S_FIRST && effCont) begin
        addrLen_reg <= contLen_reg; // opcode-less frame reuses the armed length
      end
      case (effSt)
        S_OPC: begin
          opcSh_reg <= opcNext;
          if (cnt_reg == OPC_BITS - CYC_ONE) begin
            cnt_reg <= 8'h00;
            if (opcNext == OPC_DUAL_DDR4) begin
              addrLen_reg <= ADDR4_CYC;
              st_reg      <= S_ADDR;
            end else if (opcNext == OPC_DUAL_DDR) begin
              addrLen_reg <= cfgS_reg.extendedAddressEnable ? ADDR4_CYC : ADDR3_CYC;
              st_reg      <= S_ADDR;
            end else begin
              st_reg <= S_IGNORE; // another command, not ours
            end
          end
        end
        S_ADDR: begin
          addrSh_reg <= addrFull;
          if (cnt_reg == addrLen_reg - CYC_ONE) begin
            cnt_reg     <= 8'h00;
            memAddr_reg <= addrFull[ADDR_W-1:0];
            // basic table goes straight to latency
            st_reg      <= cfgS_reg.enhancedLatencyTable ? S_MODE : S_DUMMY;
          end
        end
        S_MODE: begin
          modeSh_reg <= nib;
          if (cnt_reg == MODE_CYC - CYC_ONE) begin
            cnt_reg <= 8'h00;
            st_reg  <= S_DUMMY;
          end
        end
        S_DUMMY: begin
          // lines are not sampled here, so a floating bus does no harm
          if (cnt_reg >= dmyLen - CYC_ONE) begin
            cnt_reg <= 8'h00;
            st_reg  <= S_DATA;
          end
        end
        S_DATA: begin
          // one byte per two cycles, next byte fetched after the low nibble
          if (cnt_reg[0]) begin
            memAddr_reg <= memAddr_reg + ADDR_W'(1);
          end
        end
        default: begin
          st_reg  <= S_IGNORE;
          cnt_reg <= 8'h00;
        end
      endcase
    end
  end

  assign memAddr = memAddr_reg;

  // state that outlives a frame: continuous mode, its address length and the
  // length of the frame just ended; only the link reset clears it
  always_ff @(negedge sck or negedge lnkRstN_reg) begin
    if (!lnkRstN_reg) begin
      contMode_reg <= 1'b0;
      contLen_reg  <= ADDR4_CYC;
      frameCyc_reg <= FRAME_SAT;
    end else begin
      if (st_reg == S_FIRST) begin
        frameCyc_reg <= CYC_ONE;
        contMode_reg <= effCont;
      end else if (frameCyc_reg != FRAME_SAT) begin
        frameCyc_reg <= frameCyc_reg + CYC_ONE;
      end
      // mode byte only exists with the enhanced table, so the basic table
      // never arms; an aborted mode phase leaves the old setting alone
      if (modeDone) begin
        contMode_reg <= isComplement(modeByte);
        contLen_reg  <= addrLen_reg;
      end
    end
  end

  // preamble window: the last four dummy cycles; a shorter dummy count
  // shows only the tail of the pattern
  assign preWin = (cnt_reg + PRE_CYC) >= dmyLen;
  assign winPos = cnt_reg + PRE_CYC - dmyLen;
  assign hiIdx  = {~winPos[1:0], 1'b1};
  assign loIdx  = {~winPos[1:0], 1'b0};

  // nibble and drive for the cycle under way, from state that is stable
  // between falling edges
  always_comb begin
    curNib = 4'h0;
    curDrv = 1'b0;
    if (st_reg == S_DATA) begin
      curNib = cnt_reg[0] ? memData[3:0] : memData[7:4];
      curDrv = 1'b1;
    end else if (st_reg == S_DUMMY && cfgS_reg.learnPatternEnable && preWin) begin
      // host has let go of the lines by now
      curNib = {{2{cfgS_reg.learnPattern[hiIdx]}},
                {2{cfgS_reg.learnPattern[loIdx]}}};
      curDrv = 1'b1;
    end
  end

  // high pair launched at the rising edge
  always_ff @(posedge sck or posedge frmRst) begin
    if (frmRst) begin
      posPair_reg <= 2'h0;
      posDrv_reg  <= 1'b0;
    end else begin
      posPair_reg <= curNib[3:2];
      posDrv_reg  <= curDrv;
    end
  end

  // low pair launched at the falling edge, still of the cycle now ending
  always_ff @(negedge sck or posedge frmRst) begin
    if (frmRst) begin
      negPair_reg <= 2'h0;
      negDrv_reg  <= 1'b0;
    end else begin
      negPair_reg <= curNib[1:0];
      negDrv_reg  <= curDrv;
    end
  end

  // the clock level picks the half-cycle's pair; both halves come from flops,
  // trading a clock-as-select mux for true two-edge output without a faster clock
  assign ioOut  = sck ? posPair_reg : negPair_reg;
  assign ioOe_n = sck ? {2{~posDrv_reg}} : {2{~negDrv_reg}};

endmodule

// *** sim/ddrdio_read_props.sv ***
// port checks of the ddr dual-line read engine
`timescale 1ns/1ps
module ddrdio_read_props
  import ddrdio_pkg::*;
#(
  parameter int          ADDR_W    = 24,           // array address bits
  parameter ddrdio_dmy_t DUMMY_TAB = DUMMY_TAB_DEF // dummy cycles per code
) (
  input wire logic              clk,     // system clock
  input wire logic              rst_n,   // reset, active low
  input wire logic              sck,     // serial clock
  input wire logic              cs_n,    // chip select
  input wire logic [1:0]        ioIn,    // line levels
  input wire logic [1:0]        ioOut,   // device drive value
  input wire logic [1:0]        ioOe_n,  // device drive enable
  input wire ddrdio_cfg_t       cfg,     // configuration
  input wire logic [ADDR_W-1:0] memAddr, // array address
  input wire logic [7:0]        memData, // array byte
  input wire ddrdio_stat_t      status   // status
);
  logic [7:0] riseCnt;
  // rising edges since select fell; select high clears it at once
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) riseCnt <= 8'h00;
    else if (riseCnt != 8'hff) riseCnt <= riseCnt + 8'h01;
  end
  sequence s_driving;
    !ioOe_n[0] && !cs_n;
  endsequence
  // two driven falling edges with a new address in between
  sequence s_stepped;
    s_driving ##1 (s_driving and (memAddr != $past(memAddr)));
  endsequence
  a_oe_pair: assert property (@(posedge clk) disable iff (!rst_n)
    ioOe_n[0] == ioOe_n[1]) else $error("line enables differ");
  a_idle_off: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> ioOe_n == 2'h3) else $error("drive outside frame");
  // shortest frame reaches its first driven cycle after nine rising edges
  a_late_drive: assert property (@(posedge clk) disable iff (!rst_n)
    !ioOe_n[0] |-> riseCnt > 8'h08) else $error("drive too early");
  a_drive_holds: assert property (@(posedge sck) disable iff (!rst_n)
    s_driving |=> !ioOe_n[0] || riseCnt == 8'h00) else $error("drive dropped");
  a_addr_step: assert property (@(negedge sck) disable iff (!rst_n)
    s_stepped |-> memAddr == $past(memAddr) + 1'b1) else $error("address step");
  a_addr_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (sck && $past(sck)) |-> $stable(memAddr)) else $error("address moved");
  a_busy_sync: assert property (@(posedge clk) disable iff (!rst_n)
    status.busy == !$past(cs_n, 2)) else $error("busy late");
  a_cont_frame: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(status.contMode) |-> status.busy) else $error("mode change idle");
endmodule
bind ddrdio_read ddrdio_read_props #(.ADDR_W(ADDR_W), .DUMMY_TAB(DUMMY_TAB)) u_props (
  .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .ioIn(ioIn), .ioOut(ioOut),
  .ioOe_n(ioOe_n), .cfg(cfg), .memAddr(memAddr), .memData(memData), .status(status));

// *** sim/ddrdio_host.sv ***
// host controller model: serial clock, select and the two shared lines
`timescale 1ns/1ps
module ddrdio_host (
  output logic            sck,   // serial clock, still outside frames
  output logic            cs_n,  // chip select
  output logic [1:0]      ioIn,  // resolved line levels
  input  wire logic [1:0] ioOut, // device drive value
  input  wire logic [1:0] ioOe_n // device drive enable, low drives
);
  logic [1:0]  hostVal = 2'h0;
  logic        hostDrv = 1'b0;
  logic [1:0]  flt     = 2'h1;
  logic [15:0] pre;
  logic [7:0]  rd[$];
  // clock idles low, mode 0
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
  end
  // a released line moves every edge, so a stale value never passes
  always @(sck) flt <= ~flt;
  // wire level from both parties' enables
  always_comb for (int i = 0; i < 2; i++) ioIn[i] = !ioOe_n[i] ? ioOut[i] : hostDrv ? hostVal[i] : flt[i];
  // half cycle: set drive just after the edge, move clock, then sample the pair
  // that this edge launched; sampling before the edge would read the previous half
  task automatic half(input logic [1:0] v, input logic drv, output logic [1:0] got);
    #1 hostDrv = drv;
    hostVal = v;
    #3 sck = ~sck;
    #2 got = ioIn;
  endtask
  task automatic byte_x(input logic [7:0] b, input logic drv, output logic [7:0] got);
    logic [1:0] g;
    for (int i = 3; i >= 0; i--) begin
      half(b[2*i+:2], drv, g);
      got[2*i+:2] = g;
    end
  endtask
  // whole frame; opcode zero means none, select stays low through mode and dummy
  task automatic frame(input logic [7:0] opc, input int ab, input logic [31:0] a, input int mb,
                       input logic [7:0] m, input int dmy, input int n);
    logic [1:0] g;
    logic [7:0] b;
    rd.delete();
    #2 cs_n = 1'b0;
    for (int i = 7; i >= 0 && opc != 8'h00; i--) begin
      half({~opc[i], opc[i]}, 1'b1, g);
      half({~opc[i], opc[i]}, 1'b1, g);
    end
    for (int i = ab - 1; i >= 0; i--) byte_x(a[8*i+:8], 1'b1, b);
    if (mb != 0) byte_x(m, 1'b1, b);
    for (int i = 0; i < 2 * dmy; i++) begin
      half(2'h0, 1'b0, g);
      pre = {pre[13:0], g};
    end
    for (int i = 0; i < n; i++) begin
      byte_x(8'h00, 1'b0, b);
      rd.push_back(b);
    end
    #2 cs_n = 1'b1;
    #10;
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench of the ddr dual-line read engine
`timescale 1ns/1ps
module tb;
  import ddrdio_pkg::*;
  logic         clk   = 1'b0;
  logic         rst_n = 1'b0;
  logic         sck;
  logic         cs_n;
  logic [1:0]   ioIn;
  logic [1:0]   ioOut;
  logic [1:0]   ioOe_n;
  ddrdio_cfg_t  cfg   = '0;
  logic [23:0]  memAddr;
  logic [7:0]   memData;
  ddrdio_stat_t status;
  int           mismatches = 0;
  int           num_checks = 0;
  always #2.5 clk = ~clk;
  // bench array contents, a mix of address bytes
  function automatic logic [7:0] mf(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // preamble as seen on the pair: each pattern bit on both lines, msb first
  function automatic logic [15:0] pexp(input logic [7:0] p);
    logic [15:0] r;
    for (int i = 7; i >= 0; i--) r = {r[13:0], {2{p[i]}}};
    return r;
  endfunction
  assign memData = mf(memAddr);
  // counts the times the device starts driving the lines
  int           drvEdges = 0;
  always @(negedge ioOe_n[0]) drvEdges++;
  ddrdio_read #(.ADDR_W(24)) u_dut (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe_n(ioOe_n), .cfg(cfg), .memAddr(memAddr),
    .memData(memData), .status(status));
  ddrdio_host u_host (.sck(sck), .cs_n(cs_n), .ioIn(ioIn), .ioOut(ioOut), .ioOe_n(ioOe_n));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [23:0] a, input int n);
    for (int i = 0; i < n; i++) chk({8'h00, u_host.rd[i]}, {8'h00, mf(a + 24'(i))});
  endtask
  // status crosses on two flops, so give it a few cycles
  task automatic chk_cm(input logic exp);
    repeat (4) @(negedge clk);
    chk({15'h0, status.contMode}, {15'h0, exp});
  endtask
  task automatic set_cfg(input logic ext, enh, lp, input logic [1:0] lc, input logic [7:0] p);
    @(negedge clk);
    cfg = '{ext, enh, lp, lc, p};
  endtask
  // every latency code with preamble, 3-byte address, basic table
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      set_cfg(1'b0, 1'b0, 1'b1, 2'(c), 8'h34 + 8'(c));
      u_host.frame(OPC_DUAL_DDR, 3, 32'h0001f0 + c, 0, 8'h00, DUMMY_TAB_DEF[c], 3);
      chk(u_host.pre, pexp(8'h34 + 8'(c)));
      chk_data(24'h0001f0 + 24'(c), 3);
    end
  endtask
  // four-byte opcode with extended addressing off, read across the top; a foreign
  // opcode afterwards must leave the lines alone
  task automatic t_wrap();
    int n0;
    set_cfg(1'b0, 1'b0, 1'b0, 2'h1, 8'h00);
    u_host.frame(OPC_DUAL_DDR4, 4, 32'h12fffffe, 0, 8'h00, DUMMY_TAB_DEF[1], 4);
    chk_data(24'hfffffe, 4);
    n0 = drvEdges;
    u_host.frame(8'h0b, 3, 32'h00000100, 0, 8'h00, DUMMY_TAB_DEF[1], 2);
    chk(16'(drvEdges - n0), 16'h0000);
  endtask
  // arm, opcode-less frame, disarm, re-arm, short frame exit
  task automatic t_cont();
    set_cfg(1'b1, 1'b1, 1'b1, 2'h2, 8'h34);
    u_host.frame(OPC_DUAL_DDR, 4, 32'h00000400, 1, 8'h5a, DUMMY_TAB_DEF[2], 2);
    chk_data(24'h000400, 2);
    chk_cm(1'b1);
    u_host.frame(8'h00, 4, 32'h00000800, 1, 8'h12, DUMMY_TAB_DEF[2], 2);
    chk_data(24'h000800, 2);
    chk_cm(1'b0);
    u_host.frame(OPC_DUAL_DDR, 4, 32'h00000900, 1, 8'hf0, DUMMY_TAB_DEF[2], 1);
    chk_cm(1'b1);
    u_host.frame(8'h00, 0, 32'h0, 0, 8'h00, 3, 0);
    u_host.frame(OPC_DUAL_DDR, 4, 32'h00000a00, 1, 8'h00, DUMMY_TAB_DEF[2], 2);
    chk_data(24'h000a00, 2);
    chk_cm(1'b0);
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_codes();
    t_wrap();
    t_cont();
    stop_test();
  end
  // watchdog well past the few microseconds the frames need
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
